// >>> src/alt_pin_out_mux.sv
`timescale 1ns/1ps
`default_nettype none

// One peripheral output steered to one of two lines; the line not chosen gets nothing.
module alt_pin_out_mux (
  input wire logic i_choice,
  input wire logic i_data,
  input wire logic i_enable,
  output logic o_use_first,
  output logic o_use_second,
  output logic o_data
);

  assign o_use_first = i_enable & ~i_choice;
  assign o_use_second = i_enable & i_choice;
  assign o_data = i_data;

endmodule // alt_pin_out_mux

`default_nettype wire

// >>> src/alt_pin_params.svh
`ifndef ALT_PIN_PARAMS_SVH
`define ALT_PIN_PARAMS_SVH

// Register byte addresses on the APB slave.
`define ALT_SEL0_ADDR 12'h000
`define ALT_SEL1_ADDR 12'h004

// Field positions as bit numbers of the 8-bit registers.
`define POS_SERIAL_RX 7
`define POS_SPI_OUT 6
`define POS_SPI_SELECT 5
`define POS_PWM_TWO_B 4
`define POS_CAPCOMP_TWO 3
`define POS_PWM_ONE_D 2
`define POS_PWM_ONE_C 1
`define POS_CAPCOMP_ONE 0
`define POS_SERIAL_TX 0

// Reset values and implemented-bit masks.
`define ALT_SEL0_RESET 8'h00
`define ALT_SEL1_RESET 8'h00
`define ALT_SEL1_MASK 8'h01

`endif

// >>> src/alt_pin_pkg.sv
`default_nettype none

package alt_pin_pkg;

  // One entry per routed line, in the order of the line vector ports.
  typedef enum logic [3:0] {
    line_b0 = 4'h0,
    line_b1 = 4'h1,
    line_b2 = 4'h2,
    line_b3 = 4'h3,
    line_b5 = 4'h4,
    line_b6 = 4'h5,
    line_b7 = 4'h6,
    line_a5 = 4'h7,
    line_a6 = 4'h8,
    line_a7 = 4'h9
  } line_index_t;

  typedef logic [7:0] sel_byte_t;

endpackage

`default_nettype wire

// >>> src/alt_pin_select.sv
// Contract
// - Serial receive input taken from port B line 1 if bit 7 clear, else line 2.
// - SPI data out drives port B line 2 if bit 6 clear, else port A line 6.
// - SPI select input taken from port B line 5 if bit 5 clear, else A5.
// - PWM two B drives port B line 7 if bit 4 clear, else port A line 6.
// - Capture/compare two on port B line 6 if bit 3 clear, else port A line 7.
// - PWM one D drives port B line 7 if bit 2 clear, else port A line 6.
// - PWM one C drives port B line 6 if bit 1 clear, else port A line 7.
// - Capture/compare one on port B line 3 if bit 0 clear, else port B line 0.
// - Serial transmit/clock on port B line 2 if second register bit 0 clear, else B5.
// - Second register bits 7 to 1 ignore writes and read as zero.
// - All selection bits clear on every reset and are software readable and writable.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "alt_pin_params.svh"

module alt_pin_select
  import alt_pin_pkg::*;
#(
  parameter int NUM_LINES = 10
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Peripheral side: outputs from peripherals, with their drive enables.
  input wire logic i_spi_one_data_out,
  input wire logic i_spi_one_data_out_en,
  input wire logic i_pwm_two_output_b,
  input wire logic i_pwm_two_output_b_en,
  input wire logic i_capcomp_two_signal,
  input wire logic i_capcomp_two_signal_en,
  input wire logic i_pwm_one_output_d,
  input wire logic i_pwm_one_output_d_en,
  input wire logic i_pwm_one_output_c,
  input wire logic i_pwm_one_output_c_en,
  input wire logic i_capcomp_one_signal,
  input wire logic i_capcomp_one_signal_en,
  input wire logic i_serial_transmit_clock,
  input wire logic i_serial_transmit_clock_en,
  // Peripheral side: inputs delivered to peripherals.
  output logic o_serial_receive_data,
  output logic o_spi_one_select_in,
  output logic o_capcomp_two_signal,
  output logic o_capcomp_one_signal,
  output logic o_serial_transmit_clock,
  // Port side, indexed by line_index_t.
  input wire logic [NUM_LINES-1:0] i_line_in,
  input wire logic [NUM_LINES-1:0] i_port_out,
  input wire logic [NUM_LINES-1:0] i_port_oe_n,
  output logic [NUM_LINES-1:0] o_line_out,
  output logic [NUM_LINES-1:0] o_line_oe_n,
  output logic [NUM_LINES-1:0] o_line_claimed
);

  // The line map and the claim order below are written for exactly ten lines.
  if (NUM_LINES != 10) begin : g_bad_lines
    $error("alt_pin_select serves exactly ten routed lines");
  end

  // Reset images held at register width so a single bit can be picked out of them.
  localparam sel_byte_t SEL0_RESET = `ALT_SEL0_RESET;
  localparam sel_byte_t SEL1_RESET = `ALT_SEL1_RESET;

  // Stored selections; the second register keeps only its one implemented bit.
  sel_byte_t alt_pin_select_0_reg;
  logic alt_pin_select_1_reg;
  logic [31:0] prdata_next;
  logic rd_setup;
  logic wr_en;
  logic sel0_hit;
  logic sel1_hit;
  logic any_hit;

  // Only the two word addresses decode; any other offset is refused with an error.
  assign sel0_hit = (i_paddr == `ALT_SEL0_ADDR);
  assign sel1_hit = (i_paddr == `ALT_SEL1_ADDR);
  assign any_hit = sel0_hit | sel1_hit;
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_setup = i_psel & ~i_penable & ~i_pwrite;

  // Zero wait states; unmapped addresses read zero and flag an error.
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~any_hit;

  // A write lands at the edge that closes its access phase, and the pins follow at that same edge.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      alt_pin_select_0_reg <= SEL0_RESET;
    end else if (wr_en && sel0_hit) begin
      alt_pin_select_0_reg <= i_pwdata[7:0];
    end
  end

  // The other written bits of the second register are simply dropped here.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      alt_pin_select_1_reg <= SEL1_RESET[`POS_SERIAL_TX];
    end else if (wr_en && sel1_hit) begin
      alt_pin_select_1_reg <= i_pwdata[`POS_SERIAL_TX];
    end
  end

  // Read word chosen from the address; unimplemented bits stay tied low.
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (sel0_hit) begin
      prdata_next[7:0] = alt_pin_select_0_reg;
    end else if (sel1_hit) begin
      prdata_next[`POS_SERIAL_TX] = alt_pin_select_1_reg;
    end
  end

  // Read data registered during the setup phase so it stands still for the access phase.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      o_prdata <= prdata_next;
    end
  end

  // Each choice bit taken by name so the routing below reads like the selection table.
  logic serial_rx_pin_choice;
  logic spi_out_pin_choice;
  logic spi_select_pin_choice;
  logic pwm_two_b_pin_choice;
  logic capcomp_two_pin_choice;
  logic pwm_one_d_pin_choice;
  logic pwm_one_c_pin_choice;
  logic capcomp_one_pin_choice;
  logic serial_tx_pin_choice;
  assign serial_rx_pin_choice = alt_pin_select_0_reg[`POS_SERIAL_RX];
  assign spi_out_pin_choice = alt_pin_select_0_reg[`POS_SPI_OUT];
  assign spi_select_pin_choice = alt_pin_select_0_reg[`POS_SPI_SELECT];
  assign pwm_two_b_pin_choice = alt_pin_select_0_reg[`POS_PWM_TWO_B];
  assign capcomp_two_pin_choice = alt_pin_select_0_reg[`POS_CAPCOMP_TWO];
  assign pwm_one_d_pin_choice = alt_pin_select_0_reg[`POS_PWM_ONE_D];
  assign pwm_one_c_pin_choice = alt_pin_select_0_reg[`POS_PWM_ONE_C];
  assign capcomp_one_pin_choice = alt_pin_select_0_reg[`POS_CAPCOMP_ONE];
  assign serial_tx_pin_choice = alt_pin_select_1_reg;

  // Output functions: claim pairs for each of the seven driven functions.
  localparam int NF = 7;
  logic [NF-1:0] f_choice;
  logic [NF-1:0] f_data;
  logic [NF-1:0] f_en;
  logic [NF-1:0] f_first;
  logic [NF-1:0] f_second;
  logic [NF-1:0] f_val;

  assign f_choice = {serial_tx_pin_choice, capcomp_one_pin_choice, pwm_one_c_pin_choice,
                     pwm_one_d_pin_choice, capcomp_two_pin_choice, pwm_two_b_pin_choice,
                     spi_out_pin_choice};
  assign f_data = {i_serial_transmit_clock, i_capcomp_one_signal, i_pwm_one_output_c,
                   i_pwm_one_output_d, i_capcomp_two_signal, i_pwm_two_output_b,
                   i_spi_one_data_out};
  assign f_en = {i_serial_transmit_clock_en, i_capcomp_one_signal_en, i_pwm_one_output_c_en,
                 i_pwm_one_output_d_en, i_capcomp_two_signal_en, i_pwm_two_output_b_en,
                 i_spi_one_data_out_en};

  for (genvar g = 0; g < NF; g++) begin : g_out
    alt_pin_out_mux u_mux (
      .i_choice(f_choice[g]),
      .i_data(f_data[g]),
      .i_enable(f_en[g]),
      .o_use_first(f_first[g]),
      .o_use_second(f_second[g]),
      .o_data(f_val[g])
    );
  end

  // Line drive: a line claimed by a function carries it; else the port drives it.
  always_comb begin
    o_line_out = i_port_out;
    o_line_oe_n = i_port_oe_n;
    o_line_claimed = '0;
    // Lower-priority claims first so the more specific ones overwrite on a clash.
    if (f_first[0]) begin
      o_line_out[line_b2] = f_val[0];
      o_line_oe_n[line_b2] = 1'b0;
      o_line_claimed[line_b2] = 1'b1;
    end
    if (f_second[0]) begin
      o_line_out[line_a6] = f_val[0];
      o_line_oe_n[line_a6] = 1'b0;
      o_line_claimed[line_a6] = 1'b1;
    end
    if (f_first[1]) begin
      o_line_out[line_b7] = f_val[1];
      o_line_oe_n[line_b7] = 1'b0;
      o_line_claimed[line_b7] = 1'b1;
    end
    if (f_second[1]) begin
      o_line_out[line_a6] = f_val[1];
      o_line_oe_n[line_a6] = 1'b0;
      o_line_claimed[line_a6] = 1'b1;
    end
    if (f_first[2]) begin
      o_line_out[line_b6] = f_val[2];
      o_line_oe_n[line_b6] = 1'b0;
      o_line_claimed[line_b6] = 1'b1;
    end
    if (f_second[2]) begin
      o_line_out[line_a7] = f_val[2];
      o_line_oe_n[line_a7] = 1'b0;
      o_line_claimed[line_a7] = 1'b1;
    end
    if (f_first[3]) begin
      o_line_out[line_b7] = f_val[3];
      o_line_oe_n[line_b7] = 1'b0;
      o_line_claimed[line_b7] = 1'b1;
    end
    if (f_second[3]) begin
      o_line_out[line_a6] = f_val[3];
      o_line_oe_n[line_a6] = 1'b0;
      o_line_claimed[line_a6] = 1'b1;
    end
    if (f_first[4]) begin
      o_line_out[line_b6] = f_val[4];
      o_line_oe_n[line_b6] = 1'b0;
      o_line_claimed[line_b6] = 1'b1;
    end
    if (f_second[4]) begin
      o_line_out[line_a7] = f_val[4];
      o_line_oe_n[line_a7] = 1'b0;
      o_line_claimed[line_a7] = 1'b1;
    end
    if (f_first[5]) begin
      o_line_out[line_b3] = f_val[5];
      o_line_oe_n[line_b3] = 1'b0;
      o_line_claimed[line_b3] = 1'b1;
    end
    if (f_second[5]) begin
      o_line_out[line_b0] = f_val[5];
      o_line_oe_n[line_b0] = 1'b0;
      o_line_claimed[line_b0] = 1'b1;
    end
    if (f_first[6]) begin
      o_line_out[line_b2] = f_val[6];
      o_line_oe_n[line_b2] = 1'b0;
      o_line_claimed[line_b2] = 1'b1;
    end
    if (f_second[6]) begin
      o_line_out[line_b5] = f_val[6];
      o_line_oe_n[line_b5] = 1'b0;
      o_line_claimed[line_b5] = 1'b1;
    end
  end

  // Inputs to peripherals come from the chosen line only; the other is never looked at.
  // The serial clock path serves synchronous slave mode, where the clock comes in.
  always_comb begin
    if (serial_rx_pin_choice) begin
      o_serial_receive_data = i_line_in[line_b2];
    end else begin
      o_serial_receive_data = i_line_in[line_b1];
    end
  end

  always_comb begin
    if (spi_select_pin_choice) begin
      o_spi_one_select_in = i_line_in[line_a5];
    end else begin
      o_spi_one_select_in = i_line_in[line_b5];
    end
  end

  always_comb begin
    if (capcomp_two_pin_choice) begin
      o_capcomp_two_signal = i_line_in[line_a7];
    end else begin
      o_capcomp_two_signal = i_line_in[line_b6];
    end
  end

  always_comb begin
    if (capcomp_one_pin_choice) begin
      o_capcomp_one_signal = i_line_in[line_b0];
    end else begin
      o_capcomp_one_signal = i_line_in[line_b3];
    end
  end

  always_comb begin
    if (serial_tx_pin_choice) begin
      o_serial_transmit_clock = i_line_in[line_b5];
    end else begin
      o_serial_transmit_clock = i_line_in[line_b2];
    end
  end

endmodule // alt_pin_select

`default_nettype wire

// >>> tb/alt_pin_select_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "alt_pin_params.svh"

module alt_pin_select_props #(
  parameter int NUM_LINES = 10
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_serial_receive_data,
  input wire logic o_spi_one_select_in,
  input wire logic o_capcomp_two_signal,
  input wire logic o_capcomp_one_signal,
  input wire logic o_serial_transmit_clock,
  input wire logic [NUM_LINES-1:0] i_line_in
);
  // Shadow selections rebuilt from bus traffic, so a lost write shows up.
  logic [7:0] sel0_reg;
  logic sel1_reg;
  logic acc;
  assign acc = i_psel && i_penable && o_pready;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sel0_reg <= 8'h00;
    end else if (acc && i_pwrite && i_paddr == `ALT_SEL0_ADDR) begin
      sel0_reg <= i_pwdata[7:0];
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sel1_reg <= 1'b0;
    end else if (acc && i_pwrite && i_paddr == `ALT_SEL1_ADDR) begin
      sel1_reg <= i_pwdata[0];
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  a_rx_route: assert property (o_serial_receive_data == i_line_in[sel0_reg[7] ? 2 : 1])
    else $error("receive line wrong");
  a_ss_route: assert property (o_spi_one_select_in == i_line_in[sel0_reg[5] ? 7 : 4])
    else $error("select line wrong");
  a_cc2_route: assert property (o_capcomp_two_signal == i_line_in[sel0_reg[3] ? 9 : 5])
    else $error("capture two line wrong");
  a_cc1_route: assert property (o_capcomp_one_signal == i_line_in[sel0_reg[0] ? 0 : 3])
    else $error("capture one line wrong");
  a_tx_route: assert property (o_serial_transmit_clock == i_line_in[sel1_reg ? 4 : 2])
    else $error("transmit line wrong");
  a_pad_zero: assert property (acc && !i_pwrite && i_paddr == `ALT_SEL1_ADDR
    |-> o_prdata == {31'h0, sel1_reg}) else $error("second register read wrong");
  a_read_back: assert property (acc && !i_pwrite && i_paddr == `ALT_SEL0_ADDR
    |-> o_prdata == {24'h0, sel0_reg}) else $error("first register read wrong");
  a_bad_addr: assert property (acc && i_paddr != `ALT_SEL0_ADDR && i_paddr != `ALT_SEL1_ADDR
    |-> o_pslverr) else $error("unmapped access not flagged");
  cover property (sel0_reg == 8'hFF && sel1_reg);
  cover property (acc && i_pwrite && i_paddr == `ALT_SEL1_ADDR);
  cover property (acc && o_pslverr);
endmodule // alt_pin_select_props

bind alt_pin_select alt_pin_select_props #(.NUM_LINES(NUM_LINES)) u_alt_pin_select_props (
  .i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
  .o_pslverr, .o_serial_receive_data, .o_spi_one_select_in, .o_capcomp_two_signal,
  .o_capcomp_one_signal, .o_serial_transmit_clock, .i_line_in);
`default_nettype wire

// >>> tb/pin_pads.sv
`timescale 1ns/1ps
`default_nettype none

module pin_pads (
  input wire logic [9:0] i_drive,
  input wire logic [9:0] i_drive_oe_n,
  input wire logic [9:0] i_ext,
  output logic [9:0] o_level
);
  // An undriven pad shows the outside level, never the last driven value.
  always_comb begin
    for (int k = 0; k < 10; k++) begin
      o_level[k] = i_drive_oe_n[k] ? i_ext[k] : i_drive[k];
    end
  end
endmodule // pin_pads
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "alt_pin_params.svh"

module tb;
  logic i_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, err;
  logic o_serial_receive_data, o_spi_one_select_in, o_capcomp_two_signal;
  logic o_capcomp_one_signal, o_serial_transmit_clock;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, q;
  logic [6:0] fen, fd;
  logic [9:0] ext, i_line_in, i_port_out, i_port_oe_n, o_line_out, o_line_oe_n;
  logic [9:0] claimed;
  int bad_count, n_checks, t;
  int lo [7] = '{2, 6, 5, 6, 5, 3, 2};
  int hi [7] = '{8, 8, 9, 8, 9, 0, 4};
  alt_pin_select u_alt_pin_select (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_spi_one_data_out(fd[0]),
    .i_spi_one_data_out_en(fen[0]), .i_pwm_two_output_b(fd[1]), .i_pwm_two_output_b_en(fen[1]),
    .i_capcomp_two_signal(fd[2]), .i_capcomp_two_signal_en(fen[2]),
    .i_pwm_one_output_d(fd[3]), .i_pwm_one_output_d_en(fen[3]), .i_pwm_one_output_c(fd[4]),
    .i_pwm_one_output_c_en(fen[4]), .i_capcomp_one_signal(fd[5]),
    .i_capcomp_one_signal_en(fen[5]), .i_serial_transmit_clock(fd[6]),
    .i_serial_transmit_clock_en(fen[6]), .o_serial_receive_data, .o_spi_one_select_in,
    .o_capcomp_two_signal, .o_capcomp_one_signal, .o_serial_transmit_clock, .i_line_in,
    .i_port_out, .i_port_oe_n, .o_line_out, .o_line_oe_n, .o_line_claimed(claimed));
  pin_pads u_pin_pads (.i_drive(o_line_out), .i_drive_oe_n(o_line_oe_n), .i_ext(ext),
    .o_level(i_line_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, wr, a, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    q = o_prdata;
    err = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
  endtask
  task automatic conclude();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    bad_count++;
    conclude();
  end
  initial begin
    {i_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {4'b1000, 44'h0};
    {fen, fd, ext, i_port_out, i_port_oe_n} <= {34'h0, 10'h3FF};
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    apb(1'b1, `ALT_SEL1_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, `ALT_SEL1_ADDR, 32'h0);
    check(q, 32'h1);
    apb(1'b1, `ALT_SEL0_ADDR, 32'hA5);
    apb(1'b1, 12'h008, 32'h5A);
    check(err, 1'b1);
    check(o_pready, 1'b1);
    apb(1'b0, `ALT_SEL0_ADDR, 32'h0);
    check(q, 32'hA5);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, `ALT_SEL0_ADDR, s ? 32'hFF : 32'h0);
      apb(1'b1, `ALT_SEL1_ADDR, s);
      for (int k = 0; k < 7; k++) begin
        @(posedge i_clk);
        fen <= 7'h01 << k;
        fd <= s ? 7'h55 : 7'h2A;
        @(negedge i_clk);
        t = s ? hi[k] : lo[k];
        check(o_line_oe_n[t], 1'b0);
        check(o_line_out[t], fd[k]);
        check(o_line_oe_n[s ? lo[k] : hi[k]], 1'b1);
        check(claimed, 1 << t);
      end
      for (int e = 0; e < 2; e++) begin
        @(posedge i_clk);
        fen <= 7'h00;
        ext <= e ? 10'h31A : 10'h0E5;
        @(negedge i_clk);
        check(o_serial_receive_data, ext[s ? 2 : 1]);
        check(o_spi_one_select_in, ext[s ? 7 : 4]);
        check(o_capcomp_two_signal, ext[s ? 9 : 5]);
        check(o_capcomp_one_signal, ext[s ? 0 : 3]);
        check(o_serial_transmit_clock, ext[s ? 4 : 2]);
      end
    end
    @(posedge i_clk);
    {i_port_oe_n, i_port_out} <= {10'h000, 10'h2B5};
    @(negedge i_clk);
    check({o_line_oe_n, o_line_out}, {10'h000, 10'h2B5});
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    apb(1'b0, `ALT_SEL0_ADDR, 32'h0);
    check(q, 32'h0);
    apb(1'b0, `ALT_SEL1_ADDR, 32'h0);
    check(q, 32'h0);
    conclude();
  end
endmodule // tb
`default_nettype wire
